// ---- shared/cee_regs.vh ----
// constants for the conditional-execution condition evaluator
// assumes a 16-bit instruction word from the core's decode stage
`ifndef CEE_REGS_VH
`define CEE_REGS_VH

// instruction field positions
`define CEE_MASK_LSB 0
`define CEE_MASK_MSB 3
`define CEE_STATE_LSB 4
`define CEE_STATE_MSB 7
`define CEE_PAIR_LSB 8
`define CEE_PAIR_MSB 9
`define CEE_COUNT_BIT 12
`define CEE_TIDX_LSB 0
`define CEE_TIDX_MSB 1

// flag test field bit order
`define CEE_FLG_CARRY 0
`define CEE_FLG_OVFL 1
`define CEE_FLG_NEG 2
`define CEE_FLG_ZERO 3

// branch condition pair codes
`define CEE_PAIR_PIN_LOW 2'h0
`define CEE_PAIR_TF_ONE 2'h1
`define CEE_PAIR_TF_ZERO 2'h2
`define CEE_PAIR_NONE 2'h3

// temporary operand register indices
`define CEE_TIDX_0 2'h0
`define CEE_TIDX_1 2'h1
`define CEE_TIDX_2 2'h2
`define CEE_TIDX_NONE 2'h3

// greater-or-equal mask: zero and negative selected
`define CEE_MASK_GEQ 4'hc

// reset values and governed counts
`define CEE_ZERO4 4'h0
`define CEE_ZERO16 16'h0000
`define CEE_CNT_ONE 2'h1
`define CEE_CNT_TWO 2'h2

`endif

// ---- tb/cee_checker.sv ----
// checker for the condition evaluator; sees only its ports
// assumes one clock and async active-high reset
`timescale 1ns/10ps
`default_nettype none
module cee_checker (
    input wire logic clock, // core clock
    input wire logic rst, // async reset, active high
    input wire logic instr_valid, // request pulse
    input wire logic flags_settled, // flags current
    input wire logic acc_zero, // zero condition
    input wire logic acc_neg, // negative condition
    input wire logic acc_ovfl, // overflow condition
    input wire logic acc_carry, // carry condition
    input wire logic test_flag_bit, // test flag
    input wire logic [15:0] instr_word, // instruction
    input wire logic [1:0] treg_rd_idx, // read index
    input wire logic [1:0] cond_exec_count, // governed count
    input wire logic [1:0] branch_cond_pair, // decoded pair
    input wire logic [3:0] flag_test_field, // decoded mask
    input wire logic [3:0] flag_state_field, // decoded state
    input wire logic eval_done, // answer pulse
    input wire logic cond_met, // result
    input wire logic geq_test, // greater-or-equal mask
    input wire logic treg_idx_err // index error
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // a request taken on a settled edge
    sequence s_req;
        instr_valid && flags_settled;
    endsequence
    // a request whose pair field asks for no pin or flag test
    sequence s_req_flags_only;
        s_req ##0 (instr_word[9:8] == 2'h3);
    endsequence
    chk_done_answer: assert property (s_req |=> eval_done)
        else $error("no answer");
    chk_mask_decode: assert property (s_req |=>
        flag_test_field == $past(instr_word[3:0])) else $error("mask wrong");
    chk_state_decode: assert property (s_req |=>
        flag_state_field == $past(instr_word[7:4])) else $error("state wrong");
    chk_pair_decode: assert property (s_req |=>
        branch_cond_pair == $past(instr_word[9:8])) else $error("pair wrong");
    chk_count_decode: assert property (s_req |=>
        cond_exec_count == ($past(instr_word[12]) ? 2'h2 : 2'h1)) else $error("count wrong");
    chk_geq_mask: assert property (s_req |=>
        geq_test == ($past(instr_word[3:0]) == 4'hc)) else $error("geq wrong");
    chk_flag_result: assert property (s_req_flags_only |=> cond_met ==
        |($past(instr_word[3:0])
        & ~($past({acc_zero, acc_neg, acc_ovfl, acc_carry}) ^ $past(instr_word[7:4]))))
        else $error("result wrong");
    chk_idx_error: assert property (treg_rd_idx == 2'h3 |=> treg_idx_err)
        else $error("idx");
endmodule
bind cee_cond_eval cee_checker u_chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the condition evaluator
// assumes cee_cond_eval and its checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock = 0, rst = 1, instr_valid = 0, flags_settled = 1, acc_zero = 0, acc_neg = 0;
    logic acc_ovfl = 0, acc_carry = 0, test_flag_bit = 0, ext_branch_pin = 1, treg_we = 0;
    logic [15:0] instr_word = 0, treg_wr_data = 0, treg_rd_data;
    logic [1:0] treg_wr_idx = 0, treg_rd_idx = 0, cond_exec_count, branch_cond_pair;
    logic [3:0] flag_test_field, flag_state_field;
    logic treg_idx_err, eval_done, cond_met, geq_test;
    int failures = 0, comparisons = 0, i;
    logic [15:0] w;
    cee_cond_eval dut (.*);
    // clock of 100 ns
    initial forever #50 clock = ~clock;
    task ck(input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin failures++; $display("ERROR t=%0t seen=%h exp=%h", $time, s, e); end
    endtask
    function logic em(input logic [15:0] x, input logic [3:0] f, input logic t, p);
        em = |(x[3:0] & ~(f ^ x[7:4])) | (x[9:8] == 2'h0 & !p) | (x[9:8] == 2'h1 & t)
            | (x[9:8] == 2'h2 & !t);
    endfunction
    // one evaluation request, judged after the answering edge
    task ev(input logic [15:0] x, input logic [3:0] f, input logic t);
        @(posedge clock);
        instr_word <= x; {acc_zero, acc_neg, acc_ovfl, acc_carry} <= f;
        test_flag_bit <= t; instr_valid <= 1'b1;
        @(posedge clock); instr_valid <= 1'b0;
        @(negedge clock);
        ck(eval_done, 1);
    endtask
    task t_fields;
        for (i = 0; i < 16; i++) begin
            w = {3'h0, i[0], 2'h0, 2'h3, 4'ha, i[3:0]};
            ev(w, i[3:0] ^ 4'h5, 1'b0);
            ck(cond_met, em(w, i[3:0] ^ 4'h5, 1'b0, 1'b1));
            ck(flag_test_field, i[3:0]);
            ck(flag_state_field, 4'ha);
            ck(cond_exec_count, i[0] ? 2'h2 : 2'h1);
            ck(geq_test, i == 12);
        end
        $display("t_fields done");
    endtask
    task t_pair;
        for (i = 0; i < 6; i++) begin
            @(posedge clock) ext_branch_pin <= i[0];
            repeat (6) @(posedge clock);
            w = {6'h0, 2'(i / 2), 8'h00};
            ev(w, 4'h0, i[0]);
            ck(cond_met, em(w, 4'h0, i[0], i[0]));
            ck(branch_cond_pair, i / 2);
        end
        $display("t_pair done");
    endtask
    task t_settle;
        @(posedge clock);
        flags_settled <= 1'b0; instr_word <= 16'h0388; instr_valid <= 1'b1; acc_zero <= 1'b0;
        @(posedge clock) instr_valid <= 1'b0;
        repeat (2) @(negedge clock) ck(eval_done, 0);
        @(posedge clock) begin acc_zero <= 1'b1; flags_settled <= 1'b1; end
        @(posedge clock); @(negedge clock);
        ck(eval_done, 1);
        ck(cond_met, 1);
        $display("t_settle done");
    endtask
    task t_treg;
        for (i = 0; i < 3; i++) begin
            @(posedge clock) begin treg_we <= 1; treg_wr_idx <= 2'(i); treg_wr_data <= 16'ha5a0 + i; end
        end
        @(posedge clock) treg_we <= 0;
        for (i = 0; i < 4; i++) begin
            @(posedge clock) treg_rd_idx <= 2'(i);
            @(posedge clock); @(negedge clock);
            ck(treg_rd_data, i == 3 ? 16'h0000 : 16'ha5a0 + i);
            ck(treg_idx_err, i == 3);
        end
        $display("t_treg done");
    endtask
    task close_out;
        $display("checks %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial begin #400000; failures++; close_out; end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_fields; t_pair; t_settle; t_treg;
        close_out;
    end
endmodule
`default_nettype wire

// ---- verilog/cee_cond_eval.v ----
// condition decoder and evaluator for conditional execute, branch and call
// assumes flags come from the core on this clock after all earlier updates
`timescale 1ns/10ps
`default_nettype none
`include "cee_regs.vh"

module cee_cond_eval (
    input wire clock, // core clock, 10 MHz
    input wire rst, // async reset, active high
    input wire [15:0] instr_word, // instruction under decode
    input wire instr_valid, // one-cycle pulse: instr_word is a conditional
    input wire flags_settled, // earlier instructions have retired their flags
    input wire acc_zero, // main_sum_register equals zero
    input wire acc_neg, // main_sum_register below zero
    input wire acc_ovfl, // overflow flag
    input wire acc_carry, // carry flag
    input wire test_flag_bit, // test flag
    input wire ext_branch_pin, // external branch pin, asynchronous
    input wire treg_we, // write strobe for a temporary register
    input wire [1:0] treg_wr_idx, // index of register to write
    input wire [15:0] treg_wr_data, // data to write
    input wire [1:0] treg_rd_idx, // index of register to read
    output reg [15:0] treg_rd_data, // registered read data
    output reg treg_idx_err, // index 3 seen on last access
    output reg eval_done, // one-cycle pulse: result is valid
    output reg cond_met, // condition held
    output reg [1:0] cond_exec_count, // instructions governed (1 or 2)
    output reg [1:0] branch_cond_pair, // decoded pair field
    output reg [3:0] flag_test_field, // decoded mask
    output reg [3:0] flag_state_field, // decoded required state
    output reg geq_test // mask asks for greater-or-equal
);

// temporary operand registers
reg [15:0] temp_operand_reg [0:2];
reg pend_reg;
reg [15:0] pend_instr_reg;
wire pin_level;
wire wr_idx_bad;
wire rd_idx_bad;
wire [15:0] cur_instr;
wire [3:0] cur_flags;
reg pair_hit;
reg [3:0] sel_bits;

// pin passes the agreement synchroniser
// the pin is asynchronous to the core clock, so it is never read raw;
// a level change reaches the pair test four to five edges late, and
// a glitch shorter than one clock period is filtered out by the
// agreement of the second and third stages
cee_pin_sync u_pin (
    .clock(clock),
    .rst(rst),
    .pin_in(ext_branch_pin),
    .level_out(pin_level)
);

// index three names no register; reads give zero and flag an error
// only indices 0 to 2
function cee_idx_bad;
    input [1:0] idx;
    begin
        cee_idx_bad = (idx == `CEE_TIDX_NONE);
    end
endfunction

// count bit to number of governed instructions
// one or two instructions
function [1:0] cee_count_decode;
    input cbit;
    begin
        cee_count_decode = cbit ? `CEE_CNT_TWO : `CEE_CNT_ONE;
    end
endfunction

// pack accumulator conditions into the flag field order
// flag field order
function [3:0] cee_pack;
    input z;
    input n;
    input v;
    input c;
    begin
        cee_pack = {z, n, v, c};
    end
endfunction

// pair decode shared by evaluation
// pair field decode
function cee_pair_test;
    input [1:0] pair;
    input pin;
    input tf;
    begin
        case (pair)
            `CEE_PAIR_PIN_LOW: cee_pair_test = ~pin;
            `CEE_PAIR_TF_ONE: cee_pair_test = tf;
            `CEE_PAIR_TF_ZERO: cee_pair_test = ~tf;
            default: cee_pair_test = 1'b0;
        endcase
    end
endfunction

// current instruction: held one if waiting for flags
// while a request is pending the live instruction port is ignored, so
// the core may move on to fetch without disturbing the held word
assign cur_instr = pend_reg ? pend_instr_reg : instr_word;
// flags are read live on the edge that evaluates, never from a copy,
// so the last update before flags_settled rises is the one tested
assign cur_flags = cee_pack(acc_zero, acc_neg, acc_ovfl, acc_carry);

// index checks shared by write and read ports
assign wr_idx_bad = cee_idx_bad(treg_wr_idx);
assign rd_idx_bad = cee_idx_bad(treg_rd_idx);

// combinational evaluation of masked flags
always @*
begin
    sel_bits = cur_instr[`CEE_MASK_MSB:`CEE_MASK_LSB]
        & ~(cur_flags ^ cur_instr[`CEE_STATE_MSB:`CEE_STATE_LSB]);
    pair_hit = cee_pair_test(cur_instr[`CEE_PAIR_MSB:`CEE_PAIR_LSB], pin_level,
        test_flag_bit);
end

// hold request until flags settle, then evaluate
// only one request is held: a new instr_valid while one is pending is
// dropped, so the core must not issue another before eval_done;
// results stand until the next evaluation overwrites them
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        pend_reg <= 1'b0;
        pend_instr_reg <= `CEE_ZERO16;
        eval_done <= 1'b0;
        cond_met <= 1'b0;
        cond_exec_count <= `CEE_CNT_ONE;
        branch_cond_pair <= `CEE_PAIR_NONE;
        flag_test_field <= `CEE_ZERO4;
        flag_state_field <= `CEE_ZERO4;
        geq_test <= 1'b0;
    end
    else
    begin
        eval_done <= 1'b0;
        if (instr_valid && !flags_settled && !pend_reg)
        begin
            pend_reg <= 1'b1;
            pend_instr_reg <= instr_word;
        end
        if ((instr_valid || pend_reg) && flags_settled)
        begin
            pend_reg <= 1'b0;
            eval_done <= 1'b1;
            cond_met <= (|sel_bits) | pair_hit;
            cond_exec_count <= cee_count_decode(cur_instr[`CEE_COUNT_BIT]);
            branch_cond_pair <= cur_instr[`CEE_PAIR_MSB:`CEE_PAIR_LSB];
            flag_test_field <= cur_instr[`CEE_MASK_MSB:`CEE_MASK_LSB];
            flag_state_field <= cur_instr[`CEE_STATE_MSB:`CEE_STATE_LSB];
            geq_test <= (cur_instr[`CEE_MASK_MSB:`CEE_MASK_LSB] == `CEE_MASK_GEQ);
        end
    end
end

// temporary operand registers, write and registered read
// a write to index three is discarded rather than aliased, and a read
// of it returns zero, so software errors show up on treg_idx_err
// instead of silently corrupting a real register
// three registers, index 0-2
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        temp_operand_reg[0] <= `CEE_ZERO16;
        temp_operand_reg[1] <= `CEE_ZERO16;
        temp_operand_reg[2] <= `CEE_ZERO16;
        treg_rd_data <= `CEE_ZERO16;
        treg_idx_err <= 1'b0;
    end
    else
    begin
        if (treg_we && !wr_idx_bad)
            temp_operand_reg[treg_wr_idx] <= treg_wr_data;
        if (rd_idx_bad)
            treg_rd_data <= `CEE_ZERO16;
        else
            treg_rd_data <= temp_operand_reg[treg_rd_idx];
        treg_idx_err <= (treg_we && wr_idx_bad) || rd_idx_bad;
    end
end

endmodule

`default_nettype wire

// ---- verilog/cee_pin_sync.v ----
// three-stage synchroniser with agreement filter for an external pin
// assumes the pin is asynchronous to clock
`timescale 1ns/10ps
`default_nettype none

module cee_pin_sync (
    input wire clock, // core clock
    input wire rst, // async reset, active high
    input wire pin_in, // raw pin level
    output reg level_out // filtered level
);

reg s1_reg;
reg s2_reg;
reg s3_reg;

// shift chain; stage one feeds only stage two
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
        s3_reg <= 1'b1;
        level_out <= 1'b1;
    end
    else
    begin
        s1_reg <= pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg)
            level_out <= s3_reg;
    end
end

endmodule

`default_nettype wire
